// File: gsr_pkg.sv
// Purpose: shared constants and carriers for the status/service-request block
// Assumes: one instrument clock, synchronous active-high reset
// Notes:   bit positions follow the status byte layout
package gsr_pkg;
   // status and mask bit positions
   localparam int unsigned BIT_DISP_RDY = 0;
   localparam int unsigned BIT_CTRL_RDY = 1;
   localparam int unsigned BIT_LIMIT    = 2;
   localparam int unsigned BIT_CHAN_CHG = 3;
   localparam int unsigned BIT_SPARE4   = 4;
   localparam int unsigned BIT_OVL_ERR  = 5;
   localparam int unsigned BIT_SRQ      = 6;
   localparam int unsigned BIT_SPARE7   = 7;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MASK_RST   = 8'h00;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   // bits that carry a function in mask and status
   localparam logic [7:0] MASK_IMPL  = 8'h6f;
   localparam logic [7:0] STAT_IMPL  = 8'h2f;

   // instrument conditions feeding the status reports
   typedef struct packed {
      logic disp_valid;   // display reading valid (level)
      logic ctrl_valid;   // control reading valid (level)
      logic in_limit;     // control reading inside band (level)
      logic chan_change;  // display channel changed (pulse)
      logic ovl_err;      // overload or error present (level)
   } gsr_cond_s;
endpackage

// File: gsr_status_srq.sv
// Purpose: status byte, report mask and service-request line of a bus instrument
// Assumes: condition inputs and command strobes come from logic on core_clk_in
// Notes:   srq is open-drain; the byte returned by a poll carries bit 6 as "requested"
`timescale 1ns/100ps
module gsr_status_srq
   import gsr_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       clk_en_in,
   // instrument conditions
   input  wire gsr_cond_s  cond_in,
   // mask command (already parsed from Q and two hex digits)
   input  wire logic       mask_set_command_in,
   input  wire logic [7:0] mask_value_in,
   input  wire logic [15:0] limit_value_in,
   // serial poll read strobe
   input  wire logic       poll_read_in,
   // serial poll answer
   output logic [7:0]      poll_byte_out,
   // current mask and limit
   output logic [7:0]      mask_out,
   output logic [15:0]     limit_out,
   // srq open-drain pin: drive low when oe high
   output logic            srq_o_out,
   output logic            srq_oe_out
);

   logic [7:0]  status_q;
   logic [7:0]  status_d;
   logic [7:0]  mask_q;
   logic [15:0] limit_q;
   logic        srq_q;
   logic        srq_d;

   // status byte map, bit 7 down to 0:
   //   7  unused, reads zero
   //   6  service requested (from srq_q, not stored in status_q)
   //   5  overload or error, live
   //   4  unused, reads zero
   //   3  display channel changed, latched
   //   2  control reading inside band, latched
   //   1  control reading valid, live
   //   0  display reading valid, live
   // the mask uses the same positions; mask bit 6 gates srq_q, so both the pin and poll bit 6
   // trade-off: masked bits freeze instead of clearing, so a stale latched
   // bit can only be removed by a poll or a new mask command

   // poll read and mask command both empty the byte; one decode, two users
   function automatic logic wipe_req(input logic poll, input logic cmd);
      return poll || cmd;
   endfunction

   // mask register; spare bits never stored
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mask_q <= MASK_RST;
      end else if (clk_en_in && mask_set_command_in) begin
         mask_q <= mask_value_in & MASK_IMPL;
      end
   end

   // limit band only taken when bit 2 enabled in the new mask
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         limit_q <= LIMIT_RST;
      end else if (clk_en_in && mask_set_command_in && mask_value_in[BIT_LIMIT]) begin
         limit_q <= limit_value_in;
      end
   end

   // next status: live bits follow conditions, latched bits hold;
   // a masked-off bit keeps its old value rather than clearing
   always_comb begin
      status_d = status_q;
      if (mask_q[BIT_DISP_RDY]) begin
         status_d[BIT_DISP_RDY] = cond_in.disp_valid;
      end
      if (mask_q[BIT_CTRL_RDY]) begin
         status_d[BIT_CTRL_RDY] = cond_in.ctrl_valid;
      end
      if (mask_q[BIT_LIMIT] && cond_in.in_limit) begin
         status_d[BIT_LIMIT] = 1'b1;
      end
      if (mask_q[BIT_CHAN_CHG] && cond_in.chan_change) begin
         status_d[BIT_CHAN_CHG] = 1'b1;
      end
      if (mask_q[BIT_OVL_ERR]) begin
         status_d[BIT_OVL_ERR] = cond_in.ovl_err;
      end
      status_d = status_d & STAT_IMPL;
   end

   // status register; a read or mask command wipes everything, so a
   // condition still present reappears on the following cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         status_q <= STATUS_RST;
      end else if (clk_en_in) begin
         if (wipe_req(poll_read_in, mask_set_command_in)) begin
            status_q <= STATUS_RST;
         end else begin
            status_q <= status_d;
         end
      end
   end

   // service request: any set status bit while srq enabled; drops with the
   // poll clear or when its cause goes away
   always_comb begin
      srq_d = mask_q[BIT_SRQ] && (status_d != STATUS_RST);
      if (wipe_req(poll_read_in, mask_set_command_in)) begin
         srq_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         srq_q <= 1'b0;
      end else if (clk_en_in) begin
         srq_q <= srq_d;
      end
   end

   // poll answer comes straight from flops, any time; bit 6 reports request
   always_comb begin
      poll_byte_out         = status_q;
      poll_byte_out[BIT_SRQ] = srq_q;
   end

   // own dedicated line, independent of other bus traffic
   assign srq_o_out  = 1'b0;
   assign srq_oe_out = srq_q;
   assign mask_out   = mask_q;
   assign limit_out  = limit_q;

   // checks
   a_read_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && poll_read_in |=> status_q == STATUS_RST)
      else $error("status not cleared by poll");
   a_mask_clears: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_set_command_in |=> status_q == STATUS_RST && srq_oe_out == 1'b0)
      else $error("status not cleared by mask command");
   a_srq_disabled: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !mask_q[BIT_SRQ] && !$past(mask_q[BIT_SRQ]) |-> !srq_oe_out)
      else $error("srq while disabled");
   a_srq_raises: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_SRQ] && !poll_read_in && !mask_set_command_in
      && status_d != STATUS_RST |=> srq_oe_out)
      else $error("srq not raised");
   a_limit_latch: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && status_q[BIT_LIMIT] && !poll_read_in && !mask_set_command_in
      |=> status_q[BIT_LIMIT])
      else $error("limit bit dropped");
   a_masked_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && !mask_q[BIT_OVL_ERR] && !poll_read_in && !mask_set_command_in
      |=> $stable(status_q[BIT_OVL_ERR]))
      else $error("masked bit changed");
   a_live_ready: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_DISP_RDY] && !poll_read_in && !mask_set_command_in
      |=> status_q[BIT_DISP_RDY] == $past(cond_in.disp_valid))
      else $error("ready bit not tracking");
   a_spare_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !status_q[BIT_SPARE4] && !status_q[BIT_SPARE7] && !mask_q[BIT_SPARE4]
      && !mask_q[BIT_SPARE7])
      else $error("spare bit set");
   a_poll_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
      poll_byte_out[BIT_SRQ] == srq_oe_out)
      else $error("poll byte srq flag wrong");
   c_srq_poll: cover property (@(posedge core_clk_in) disable iff (rst_in)
      srq_oe_out ##1 poll_read_in ##1 !srq_oe_out);
   c_chan_latch: cover property (@(posedge core_clk_in) disable iff (rst_in)
      status_q[BIT_CHAN_CHG] ##3 status_q[BIT_CHAN_CHG]);
   c_limit_set: cover property (@(posedge core_clk_in) disable iff (rst_in)
      mask_set_command_in && mask_value_in[BIT_LIMIT]);

   // timing of the checks below: every strobe is taken on a rising edge
   // with clk_en_in high and shows on the flops one edge later, so most
   // checks are one-cycle implications; a mask command or poll read in
   // the same cycle always wins, which is why the live-bit checks exclude
   // both; while clk_en_in is low nothing may move, reset excepted
   // limitation: these watch the byte, not the far-end bus timing

   // bit 0 sets while the display reading is valid
   a_disp_sets: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_DISP_RDY] && cond_in.disp_valid
      && !poll_read_in && !mask_set_command_in |=> status_q[BIT_DISP_RDY])
      else $error("display ready bit not set");

   // bit 1 tracks the control reading while enabled
   a_ctrl_live: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_CTRL_RDY] && !poll_read_in && !mask_set_command_in
      |=> status_q[BIT_CTRL_RDY] == $past(cond_in.ctrl_valid))
      else $error("control ready bit not tracking");

   // bit 5 tracks overload or error while enabled
   a_ovl_live: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_OVL_ERR] && !poll_read_in && !mask_set_command_in
      |=> status_q[BIT_OVL_ERR] == $past(cond_in.ovl_err))
      else $error("overload bit not tracking");

   // bit 5 is not latched: it drops with its cause
   a_ovl_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_OVL_ERR] && !cond_in.ovl_err
      && !poll_read_in && !mask_set_command_in |=> !status_q[BIT_OVL_ERR])
      else $error("overload bit latched");

   // display ready drops once the reading is no longer valid
   a_disp_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_DISP_RDY] && !cond_in.disp_valid
      && !poll_read_in && !mask_set_command_in |=> !status_q[BIT_DISP_RDY])
      else $error("display ready bit stuck");

   // control ready drops once the reading is no longer valid
   a_ctrl_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_CTRL_RDY] && !cond_in.ctrl_valid
      && !poll_read_in && !mask_set_command_in |=> !status_q[BIT_CTRL_RDY])
      else $error("control ready bit stuck");

   // reading inside the band sets bit 2
   a_limit_sets: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_LIMIT] && cond_in.in_limit
      && !poll_read_in && !mask_set_command_in |=> status_q[BIT_LIMIT])
      else $error("limit bit not set");

   // a channel change pulse sets bit 3
   a_chan_sets: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_q[BIT_CHAN_CHG] && cond_in.chan_change
      && !poll_read_in && !mask_set_command_in |=> status_q[BIT_CHAN_CHG])
      else $error("channel change bit not set");

   // bit 3 stays latched until the byte is emptied
   a_chan_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && status_q[BIT_CHAN_CHG] && !poll_read_in && !mask_set_command_in
      |=> status_q[BIT_CHAN_CHG])
      else $error("channel change bit dropped");

   // masked-off channel bit may not move
   a_chan_masked: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && !mask_q[BIT_CHAN_CHG] && !poll_read_in && !mask_set_command_in
      |=> $stable(status_q[BIT_CHAN_CHG]))
      else $error("masked channel bit changed");

   // masked-off limit bit may not move
   a_limit_masked: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && !mask_q[BIT_LIMIT] && !poll_read_in && !mask_set_command_in
      |=> $stable(status_q[BIT_LIMIT]))
      else $error("masked limit bit changed");

   // only the five report positions can ever hold a one
   a_status_width: assert property (@(posedge core_clk_in) disable iff (rst_in)
      (status_q & ~STAT_IMPL) == STATUS_RST)
      else $error("status bit outside reports");

   // accepted mask command stores the implemented bits
   a_mask_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_set_command_in
      |=> mask_q == ($past(mask_value_in) & MASK_IMPL))
      else $error("mask not written");

   // mask only changes through its command
   a_mask_keep: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !(clk_en_in && mask_set_command_in)
      |=> $stable(mask_q))
      else $error("mask changed without command");

   // limit band taken with a command enabling bit 2
   a_limit_take: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && mask_set_command_in && mask_value_in[BIT_LIMIT]
      |=> limit_q == $past(limit_value_in))
      else $error("limit band not taken");

   // limit band left alone otherwise
   a_limit_keep: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !(clk_en_in && mask_set_command_in && mask_value_in[BIT_LIMIT])
      |=> $stable(limit_q))
      else $error("limit band changed");

   // clock enable low freezes the byte, mask and pin
   a_freeze_all: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !clk_en_in
      |=> $stable(status_q) && $stable(mask_q) && $stable(srq_oe_out))
      else $error("state moved while frozen");

   // pin only pulled while a cause is held and requests are enabled
   a_srq_cause: assert property (@(posedge core_clk_in) disable iff (rst_in)
      srq_oe_out
      |-> status_q != STATUS_RST && mask_q[BIT_SRQ])
      else $error("srq without cause");

   // a poll or mask command releases the pin
   a_srq_gone: assert property (@(posedge core_clk_in) disable iff (rst_in)
      clk_en_in && (poll_read_in || mask_set_command_in)
      |=> !srq_oe_out)
      else $error("srq kept after poll");

   // reset empties mask, byte and limit and releases the pin
   a_reset_clear: assert property (@(posedge core_clk_in)
      rst_in
      |=> mask_q == MASK_RST && status_q == STATUS_RST && !srq_oe_out && limit_q == LIMIT_RST)
      else $error("reset left state behind");

   // a mask command sent while frozen
   c_freeze_cmd: cover property (@(posedge core_clk_in) disable iff (rst_in)
      !clk_en_in && mask_set_command_in);

   // overload reported with the pin disabled
   c_ovl_quiet: cover property (@(posedge core_clk_in) disable iff (rst_in)
      status_q[BIT_OVL_ERR] && !srq_oe_out);
endmodule

// File: gsr_ctl_model.sv
// Purpose: bus controller model that serial-polls on a service request
// Assumes: strobes change at the falling edge, one clock domain
// Notes:   auto_in lets the bench choose when the controller reacts
`timescale 1ns/100ps
module gsr_ctl_model (
   // clock and control
   input  wire logic       core_clk_in,
   input  wire logic       auto_in,
   // device side
   input  wire logic       srq_oe_in,
   input  wire logic [7:0] poll_byte_in,
   output logic            poll_read_out,
   output logic [7:0]      last_byte_out
);
   initial poll_read_out = 1'b0;
   initial last_byte_out = 8'h00;
   // one-cycle poll per request; the gap cycle keeps strobes from merging
   always @(negedge core_clk_in) begin
      if (auto_in && srq_oe_in && !poll_read_out) begin
         last_byte_out <= poll_byte_in;
         poll_read_out <= 1'b1;
      end else begin
         poll_read_out <= 1'b0;
      end
   end
endmodule

// File: tb.sv
// Purpose: self-checking bench for the status and service-request block
// Assumes: all inputs change at the falling clock edge
// Notes:   clock enable is dropped once to prove the freeze
`timescale 1ns/100ps
module tb import gsr_pkg::*; ;
   logic        core_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
   logic        cmd = 1'b0, tb_poll = 1'b0, m_poll, auto = 1'b0, srq_o, srq_oe;
   gsr_cond_s   cond = '0;
   logic [7:0]  mval = 8'h00, pbyte, mask, last;
   logic [15:0] lval = 16'h0000, limit;
   int          mismatches = 0, n_tests = 0, cycles = 0;
   always #5 core_clk_in = ~core_clk_in;
   // ceiling far above the 38 cycles the tests need
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   gsr_status_srq gsr_status_srq_i (.core_clk_in, .rst_in, .clk_en_in, .cond_in(cond),
      .mask_set_command_in(cmd), .mask_value_in(mval), .limit_value_in(lval),
      .poll_read_in(tb_poll | m_poll), .poll_byte_out(pbyte), .mask_out(mask),
      .limit_out(limit), .srq_o_out(srq_o), .srq_oe_out(srq_oe));
   gsr_ctl_model gsr_ctl_model_i (.core_clk_in, .auto_in(auto), .srq_oe_in(srq_oe),
      .poll_byte_in(pbyte), .poll_read_out(m_poll), .last_byte_out(last));
   task cyc(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // mask command built from its two hex digits, high nibble first
   task set_mask(input logic [3:0] hi, lo, input logic [15:0] lim);
      mval <= {hi, lo};
      lval <= lim;
      cmd  <= 1'b1;
      cyc(1);
      cmd  <= 1'b0;
   endtask
   task t_ready;
      set_mask(4'h4, 4'h1, 16'h0000);
      cond.disp_valid <= 1'b1;
      cyc(2);
      chk(pbyte, 8'h41);
      chk(srq_oe, 1'b1);
      cond.disp_valid <= 1'b0;
      cyc(2);
      chk(pbyte, 8'h00);
      chk(srq_oe, 1'b0);
      cond.disp_valid <= 1'b1;
      auto <= 1'b1;
      cyc(6);
      chk(last, 8'h41);
      auto <= 1'b0;
      cond.disp_valid <= 1'b0;
      cyc(3);
      $display("test ready done");
   endtask
   task t_latch;
      set_mask(4'h4, 4'hc, 16'h0001);
      chk(limit, 16'h0001);
      cond.chan_change <= 1'b1;
      cond.in_limit <= 1'b1;
      cyc(1);
      cond.chan_change <= 1'b0;
      cond.in_limit <= 1'b0;
      cyc(3);
      chk(pbyte, 8'h4c);
      tb_poll <= 1'b1;
      cyc(1);
      tb_poll <= 1'b0;
      chk(pbyte, 8'h00);
      chk(srq_oe, 1'b0);
      $display("test latch done");
   endtask
   task t_nosrq;
      set_mask(4'h2, 4'hf, 16'h0001);
      cond <= 5'b11111;
      cyc(1);
      cond.chan_change <= 1'b0;
      cyc(2);
      chk(pbyte, 8'h2f);
      chk(srq_oe, 1'b0);
      $display("test no-srq done");
   endtask
   // reports still live, so the clear shows for exactly one cycle
   task t_mask;
      set_mask(4'h9, 4'h1, 16'h0002);
      chk(pbyte, 8'h00);
      chk(mask, 8'h01);
      cyc(1);
      chk(pbyte, 8'h01);
      chk(limit, 16'h0001);
      clk_en_in <= 1'b0;
      set_mask(4'h6, 4'hf, 16'h0000);
      cyc(2);
      chk(mask, 8'h01);
      clk_en_in <= 1'b1;
      cond <= '0;
      $display("test mask done");
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      cyc(8);
      rst_in <= 1'b0;
      cyc(1);
      chk({srq_o, srq_oe, pbyte, mask}, 18'h0);
      t_ready();
      t_latch();
      t_nosrq();
      t_mask();
      give_verdict();
   end
endmodule
